// ===== hv_awg_ctrl_pkg.sv
package hv_awg_ctrl_pkg;

	// Register bus geometry
	localparam int ADDR_W = 8;                    // Register address width
	localparam int DATA_W = 8;                    // Register data width

	// Register addresses
	localparam logic [7:0] ADDR_DRIVER_MODE  = 8'h00; // driver_and_mode_control
	localparam logic [7:0] ADDR_DAC_POWER    = 8'h01; // dac_power_and_format_control
	localparam logic [7:0] ADDR_PATTERN      = 8'h02; // pattern_generator_control
	localparam logic [7:0] ADDR_SOFT_RESET   = 8'h03; // engine_soft_reset_control

	// Reset values of the four registers
	localparam logic [7:0] RST_DRIVER_MODE   = 8'h10;
	localparam logic [7:0] RST_DAC_POWER     = 8'h08;
	localparam logic [7:0] RST_PATTERN       = 8'h03;
	localparam logic [7:0] RST_SOFT_RESET    = 8'h00;

	// Writable bit masks; reserved positions are never stored
	localparam logic [7:0] MASK_DRIVER_MODE  = 8'h91;
	localparam logic [7:0] MASK_DAC_POWER    = 8'h2a;
	localparam logic [7:0] MASK_PATTERN      = 8'h3f;
	localparam logic [7:0] MASK_SOFT_RESET   = 8'h01;

	// Field positions in driver_and_mode_control
	localparam int BIT_LATCH_CLEAR   = 7;         // driver_latch_clear
	localparam int BIT_POWER_ON      = 4;         // driver_power_on
	localparam int BIT_SOURCE_SELECT = 0;         // waveform_source_select

	// Field positions in dac_power_and_format_control
	localparam int BIT_KEEP_POWERED  = 5;         // keep_converter_powered
	localparam int BIT_CONV_SLEEP    = 3;         // converter_sleep
	localparam int BIT_WORD_FORMAT   = 1;         // converter_word_format

	// Field positions in pattern_generator_control
	localparam int BIT_PATTERN_EN    = 5;         // pattern_mode_enable
	localparam int BIT_EDGE_SELECT   = 4;         // Falling edge when set
	localparam int DEPTH_LSB         = 0;         // Pattern depth field low bit
	localparam int DEPTH_W           = 4;         // Pattern depth field width

	// Field position in engine_soft_reset_control
	localparam int BIT_SOFT_RESET    = 0;

	// Converter word width
	localparam int WORD_W            = 14;

	// Waveform source encoding
	typedef enum logic {
		SRC_ARBITRARY = 1'b0,                     // arbitrary_waveform_mode
		SRC_PATTERN   = 1'b1                      // level_pattern_mode
	} source_t;

	// Decoded control fields shared by the engine
	typedef struct packed {
		logic                 driver_latch_clear;
		logic                 driver_power_on;
		source_t              waveform_source_select;
		logic                 keep_converter_powered;
		logic                 converter_sleep;
		logic                 converter_word_format;
		logic                 pattern_mode_enable;
		logic                 falling_edge_select;
		logic [DEPTH_W-1:0]   pattern_depth;
	} ctrl_fields_t;

endpackage

// ===== level_pattern_stepper.sv
`timescale 1ns/100ps
module level_pattern_stepper
	import hv_awg_ctrl_pkg::*;
#(
	parameter int DEPTH_BITS = DEPTH_W            // Width of the level index
) (
	input  wire logic                  mclk_in,             // System clock
	input  wire logic                  rst_b_in,            // Async reset, active low
	input  wire logic                  restart_in,          // Engine restart pulse
	input  wire logic                  active_in,           // Pattern generation running
	input  wire logic                  falling_in,          // Step on falling edge when set
	input  wire logic [DEPTH_BITS-1:0] depth_in,            // Last index before wrap
	input  wire logic                  sync_pin_in,         // Sync pin, asynchronous
	output logic                       step_out,            // One-cycle step pulse
	output logic      [DEPTH_BITS-1:0] index_out            // Current level index
);

	logic                  sync_meta_reg;                   // First synchroniser stage
	logic                  sync_safe_reg;                   // Second synchroniser stage
	logic                  sync_prev_reg;                   // Delayed copy for edge detect
	logic                  rise_edge;                       // Rising edge seen
	logic                  fall_edge;                       // Falling edge seen
	logic                  edge_hit;                        // Chosen edge seen
	logic                  at_depth;                        // Index at last level
	logic [DEPTH_BITS-1:0] index_reg;                       // Level index
	logic [DEPTH_BITS-1:0] index_next;                      // Next level index

	// Edge decode only from the second stage onward
	assign rise_edge  = sync_safe_reg & ~sync_prev_reg;
	assign fall_edge  = ~sync_safe_reg & sync_prev_reg;
	assign edge_hit   = falling_in ? fall_edge : rise_edge;
	assign step_out   = active_in & edge_hit;
	assign at_depth   = (index_reg >= depth_in);
	assign index_next = at_depth ? '0 : index_reg + 1'b1;
	assign index_out  = index_reg;

	// Two-stage synchroniser and edge history
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync_meta_reg <= 1'b0;
			sync_safe_reg <= 1'b0;
			sync_prev_reg <= 1'b0;
		end else begin
			sync_meta_reg <= sync_pin_in;
			sync_safe_reg <= sync_meta_reg;
			sync_prev_reg <= sync_safe_reg;
		end
	end

	// Level index: parked at zero while idle, advanced on each step
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			index_reg <= '0;
		end else if (restart_in || !active_in) begin
			index_reg <= '0;
		end else if (step_out) begin
			index_reg <= index_next;
		end
	end

endmodule

// ===== hv_awg_control_registers.sv
`timescale 1ns/100ps
// Functional notes
// - Latch clear bit set clears shutdown latch
// - Clear bit stays; suppresses shutdown while set
// - Power-on bit zero forces driver off, floating
// - Power-on bit one: pin, protection still act
// - Source select: zero arbitrary, one pattern
// - Pattern runs only with enable and source
// - Keep-powered zero: driver shutdown stops converter
// - Converter sleep one powers converter down
// - Word format: straight binary or two's complement
// - Pattern steps on chosen sync edge
// - Index advances, wraps after depth value
// - Depth resets to three, maximum fifteen
// - Soft reset restores registers, restarts engine
module hv_awg_control_registers
	import hv_awg_ctrl_pkg::*;
(
	input  wire logic                                mclk_in,           // System clock
	input  wire logic                                rst_b_in,          // Async reset, low
	input  wire logic [hv_awg_ctrl_pkg::ADDR_W-1:0]  reg_addr_in,       // Register address
	input  wire logic [hv_awg_ctrl_pkg::DATA_W-1:0]  reg_wdata_in,      // Write data
	input  wire logic                                reg_wr_in,         // Write strobe
	input  wire logic                                reg_rd_in,         // Read strobe
	output logic      [hv_awg_ctrl_pkg::DATA_W-1:0]  reg_rdata_out,     // Read data, next cycle
	input  wire logic                                shutdown_pin_in,   // Shutdown pin, high=stop
	input  wire logic                                fault_trip_in,     // Protection trip, async
	input  wire logic                                sync_pin_in,       // Pattern step pin
	input  wire logic [hv_awg_ctrl_pkg::WORD_W-1:0]  dac_word_in,       // Converter input word
	input  wire logic                                dac_word_valid_in, // Word strobe
	output logic                                     driver_enable_out, // Driver powered
	output logic                                     driver_float_out,  // Output high impedance
	output logic                                     latch_tripped_out, // Shutdown latch state
	output logic                                     converter_off_out, // Converter powered down
	output logic [hv_awg_ctrl_pkg::WORD_W-1:0]       dac_code_out,      // Offset-binary code
	output logic                                     dac_update_out,    // Code updated pulse
	output logic                                     pattern_active_out,// Pattern mode running
	output logic [hv_awg_ctrl_pkg::DEPTH_W-1:0]      level_index_out,   // Pattern level index
	output logic                                     engine_restart_out // Soft reset restart pulse
);
	import hv_awg_ctrl_pkg::*;

	// Stored register images
	logic [DATA_W-1:0] driver_mode_reg;            // driver_and_mode_control
	logic [DATA_W-1:0] dac_power_reg;              // dac_power_and_format_control
	logic [DATA_W-1:0] pattern_reg;                // pattern_generator_control
	logic [DATA_W-1:0] soft_reset_reg;             // engine_soft_reset_control

	// Read path
	logic [DATA_W-1:0] rdata_reg;                  // Registered read data
	logic [DATA_W-1:0] rdata_next;                 // Selected read data

	// Address decode
	logic              hit_driver_mode;            // Address is register 0
	logic              hit_dac_power;              // Address is register 1
	logic              hit_pattern;                // Address is register 2
	logic              hit_soft_reset;             // Address is register 3
	logic              wr_driver_mode;             // Write to register 0
	logic              wr_dac_power;               // Write to register 1
	logic              wr_pattern;                 // Write to register 2
	logic              wr_soft_reset;              // Write to register 3

	// Engine state
	ctrl_fields_t      ctrl;                       // Decoded fields
	logic              restart;                    // Soft reset in progress
	logic              pin_meta_reg;               // Shutdown pin stage 1
	logic              pin_safe_reg;               // Shutdown pin stage 2
	logic              trip_meta_reg;              // Fault stage 1
	logic              trip_safe_reg;              // Fault stage 2
	logic              latch_reg;                  // Shutdown latch
	logic              latch_next;                 // Next shutdown latch
	logic              driver_stopped;             // Driver shut by any cause
	logic              pattern_active;             // Pattern generation running
	logic              pattern_step;               // Sync step from stepper
	logic [WORD_W-1:0] code_reg;                   // Code held for converter
	logic [WORD_W-1:0] code_next;                  // Word in offset binary
	logic              update_reg;                 // Code update pulse
	logic              load_code;                  // Take a new code

	// Address decode is shared by reads and writes
	assign hit_driver_mode = (reg_addr_in == ADDR_DRIVER_MODE);
	assign hit_dac_power   = (reg_addr_in == ADDR_DAC_POWER);
	assign hit_pattern     = (reg_addr_in == ADDR_PATTERN);
	assign hit_soft_reset  = (reg_addr_in == ADDR_SOFT_RESET);

	// Write enables per register
	assign wr_driver_mode  = reg_wr_in & hit_driver_mode;
	assign wr_dac_power    = reg_wr_in & hit_dac_power;
	assign wr_pattern      = reg_wr_in & hit_pattern;
	assign wr_soft_reset   = reg_wr_in & hit_soft_reset;

	// A stored soft reset bit triggers the restart on the following edge
	assign restart = soft_reset_reg[BIT_SOFT_RESET];

	// Field decode from the stored images
	assign ctrl.driver_latch_clear     = driver_mode_reg[BIT_LATCH_CLEAR];
	assign ctrl.driver_power_on        = driver_mode_reg[BIT_POWER_ON];
	assign ctrl.waveform_source_select = source_t'(driver_mode_reg[BIT_SOURCE_SELECT]);
	assign ctrl.keep_converter_powered = dac_power_reg[BIT_KEEP_POWERED];
	assign ctrl.converter_sleep        = dac_power_reg[BIT_CONV_SLEEP];
	assign ctrl.converter_word_format  = dac_power_reg[BIT_WORD_FORMAT];
	assign ctrl.pattern_mode_enable    = pattern_reg[BIT_PATTERN_EN];
	assign ctrl.falling_edge_select    = pattern_reg[BIT_EDGE_SELECT];
	assign ctrl.pattern_depth          = pattern_reg[DEPTH_LSB +: DEPTH_W];

	// Read mux; unmapped addresses and reserved bits read zero
	assign rdata_next = !reg_rd_in      ? '0 :
	                    hit_driver_mode ? driver_mode_reg :
	                    hit_dac_power   ? dac_power_reg   :
	                    hit_pattern     ? pattern_reg     :
	                    hit_soft_reset  ? soft_reset_reg  : '0;
	assign reg_rdata_out = rdata_reg;

	// Register 0: latch clear, power-on and source select
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			driver_mode_reg <= RST_DRIVER_MODE;
		end else if (restart) begin
			driver_mode_reg <= RST_DRIVER_MODE;
		end else if (wr_driver_mode) begin
			driver_mode_reg <= reg_wdata_in & MASK_DRIVER_MODE;
		end
	end

	// Register 1: converter power and word format
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dac_power_reg <= RST_DAC_POWER;
		end else if (restart) begin
			dac_power_reg <= RST_DAC_POWER;
		end else if (wr_dac_power) begin
			dac_power_reg <= reg_wdata_in & MASK_DAC_POWER;
		end
	end

	// Register 2: pattern enable, edge and depth (reset depth 3)
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pattern_reg <= RST_PATTERN;
		end else if (restart) begin
			pattern_reg <= RST_PATTERN;
		end else if (wr_pattern) begin
			pattern_reg <= reg_wdata_in & MASK_PATTERN;
		end
	end

	// Register 3: soft reset clears itself along with the others
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			soft_reset_reg <= RST_SOFT_RESET;
		end else if (restart) begin
			soft_reset_reg <= RST_SOFT_RESET;
		end else if (wr_soft_reset) begin
			soft_reset_reg <= reg_wdata_in & MASK_SOFT_RESET;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Shutdown pin and fault trip cross in through two flip-flops
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_meta_reg  <= 1'b0;
			pin_safe_reg  <= 1'b0;
			trip_meta_reg <= 1'b0;
			trip_safe_reg <= 1'b0;
		end else begin
			pin_meta_reg  <= shutdown_pin_in;
			pin_safe_reg  <= pin_meta_reg;
			trip_meta_reg <= fault_trip_in;
			trip_safe_reg <= trip_meta_reg;
		end
	end

	// Latch: a trip sets it unless the clear bit holds it open
	assign latch_next = ctrl.driver_latch_clear ? 1'b0 :
	                    (latch_reg | trip_safe_reg);

	// Shutdown latch, also cleared by the engine restart
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			latch_reg <= 1'b0;
		end else if (restart) begin
			latch_reg <= 1'b0;
		end else begin
			latch_reg <= latch_next;
		end
	end

	// Power-on bit low wins over everything; else pin or latch stop it,
	// except while the clear bit suppresses all shutdown
	assign driver_stopped = !ctrl.driver_power_on ||
	                        (!ctrl.driver_latch_clear &&
	                         (pin_safe_reg || latch_reg));
	assign driver_enable_out = ~driver_stopped;
	assign driver_float_out  = driver_stopped;
	assign latch_tripped_out = latch_reg;

	// Converter powers down when asleep, or with the driver unless kept on
	assign converter_off_out = ctrl.converter_sleep ||
	                           (driver_stopped && !ctrl.keep_converter_powered);

	// Pattern mode needs both the source select and the enable bit
	assign pattern_active = (ctrl.waveform_source_select == SRC_PATTERN) &&
	                        ctrl.pattern_mode_enable;
	assign pattern_active_out = pattern_active;

	// Sync edge detection and level index
	level_pattern_stepper #(
		.DEPTH_BITS (DEPTH_W)
	) u_stepper (
		.mclk_in     (mclk_in),
		.rst_b_in    (rst_b_in),
		.restart_in  (restart),
		.active_in   (pattern_active),
		.falling_in  (ctrl.falling_edge_select),
		.depth_in    (ctrl.pattern_depth),
		.sync_pin_in (sync_pin_in),
		.step_out    (pattern_step),
		.index_out   (level_index_out)
	);

	// Arbitrary mode takes each word strobe; pattern mode each sync step;
	// with pattern source but enable clear, nothing is loaded
	assign load_code = pattern_active ? pattern_step :
	                   (ctrl.waveform_source_select == SRC_ARBITRARY) && dac_word_valid_in;

	// Two's complement is turned into offset binary by flipping the sign
	assign code_next = ctrl.converter_word_format ?
	                   {~dac_word_in[WORD_W-1], dac_word_in[WORD_W-2:0]} :
	                   dac_word_in;

	// Converter code register and its update pulse
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			code_reg   <= '0;
			update_reg <= 1'b0;
		end else begin
			update_reg <= load_code;
			if (load_code) begin
				code_reg <= code_next;
			end
		end
	end

	// Outputs from the code path
	assign dac_code_out       = code_reg;
	assign dac_update_out     = update_reg;
	assign engine_restart_out = restart;

endmodule

// ===== hv_awg_ctrl_props.sv
`timescale 1ns/100ps
module hv_awg_ctrl_props (
	input wire logic                               mclk_in,            // Clock
	input wire logic                               rst_b_in,           // Reset, active low
	input wire logic [hv_awg_ctrl_pkg::ADDR_W-1:0] reg_addr_in,        // Address
	input wire logic [hv_awg_ctrl_pkg::DATA_W-1:0] reg_wdata_in,       // Write data
	input wire logic                               reg_wr_in,          // Write strobe
	input wire logic                               reg_rd_in,          // Read strobe
	input wire logic [hv_awg_ctrl_pkg::DATA_W-1:0] reg_rdata_out,      // Read data
	input wire logic                               shutdown_pin_in,    // Shutdown pin
	input wire logic                               fault_trip_in,      // Protection trip
	input wire logic                               sync_pin_in,        // Step pin
	input wire logic [hv_awg_ctrl_pkg::WORD_W-1:0] dac_word_in,        // Word in
	input wire logic                               dac_word_valid_in,  // Word strobe
	input wire logic                               driver_enable_out,  // Driver on
	input wire logic                               driver_float_out,   // Driver floating
	input wire logic                               latch_tripped_out,  // Latch state
	input wire logic                               converter_off_out,  // Converter off
	input wire logic [hv_awg_ctrl_pkg::WORD_W-1:0] dac_code_out,       // Code out
	input wire logic                               dac_update_out,     // Update pulse
	input wire logic                               pattern_active_out, // Pattern running
	input wire logic [hv_awg_ctrl_pkg::DEPTH_W-1:0] level_index_out,   // Level index
	input wire logic                               engine_restart_out  // Restart pulse
);
	import hv_awg_ctrl_pkg::*;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	// Accepted write to the first register
	sequence mode_wr;
		reg_wr_in && reg_addr_in == ADDR_DRIVER_MODE && !engine_restart_out;
	endsequence
	// Write, idle cycle, then read of the same register
	sequence wr_then_rd;
		mode_wr ##1 !reg_wr_in ##1 (reg_rd_in && reg_addr_in == ADDR_DRIVER_MODE);
	endsequence
	// Soft reset bit written outside a restart
	sequence soft_wr;
		reg_wr_in && reg_addr_in == ADDR_SOFT_RESET && reg_wdata_in[BIT_SOFT_RESET]
			&& !engine_restart_out;
	endsequence
	float_inverse_a: assert property (driver_float_out == !driver_enable_out)
		else $error("float output is not the inverse of enable");
	power_off_a: assert property (mode_wr and !reg_wdata_in[BIT_POWER_ON] |=> !driver_enable_out)
		else $error("driver still enabled after power bit cleared");
	latch_stop_a: assert property (latch_tripped_out ##1 latch_tripped_out
		|-> !$past(driver_enable_out))
		else $error("driver enabled while latch tripped");
	latch_clear_a: assert property (mode_wr and reg_wdata_in[BIT_LATCH_CLEAR] |=> ##1 !latch_tripped_out)
		else $error("latch not cleared by clear bit");
	read_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == '0)
		else $error("read data not zero outside read answer");
	unmapped_rd_a: assert property (reg_rd_in && reg_addr_in > ADDR_SOFT_RESET |=> reg_rdata_out == '0)
		else $error("unmapped read not zero");
	write_read_a: assert property (wr_then_rd |=> reg_rdata_out == ($past(reg_wdata_in, 3) & MASK_DRIVER_MODE))
		else $error("read back differs from masked write");
	soft_reset_a: assert property (soft_wr |=> engine_restart_out ##1 (!engine_restart_out && converter_off_out && !pattern_active_out))
		else $error("soft reset sequence wrong");
	index_idle_a: assert property (!pattern_active_out ##1 !pattern_active_out |-> level_index_out == '0)
		else $error("index moves while pattern inactive");
	step_update_a: assert property ($changed(level_index_out) && pattern_active_out && $past(pattern_active_out) |-> dac_update_out)
		else $error("index stepped without converter update");
endmodule

// ===== hv_awg_control_registers_tb.sv
`timescale 1ns/100ps
module hv_awg_control_registers_tb;
	import hv_awg_ctrl_pkg::*;
	logic              mclk_in = 1'b0;       // Bench clock
	logic              rst_b_in = 1'b0;      // Reset, active low
	logic [ADDR_W-1:0] reg_addr_in = '0;     // Bus address
	logic [DATA_W-1:0] reg_wdata_in = '0;    // Bus write data
	logic              reg_wr_in = 1'b0;     // Write strobe
	logic              reg_rd_in = 1'b0;     // Read strobe
	logic [DATA_W-1:0] reg_rdata_out;        // Bus read data
	logic              shutdown_pin_in = 1'b0; // Shutdown pin
	logic              fault_trip_in = 1'b0; // Protection trip
	logic              sync_pin_in = 1'b0;   // Step pin
	logic [WORD_W-1:0] dac_word_in = '0;     // Converter word
	logic              dac_word_valid_in = 1'b0; // Word strobe
	logic              driver_enable_out, driver_float_out, latch_tripped_out;
	logic              converter_off_out, dac_update_out, pattern_active_out, engine_restart_out;
	logic [WORD_W-1:0] dac_code_out;         // Converter code
	logic [DEPTH_W-1:0] level_index_out;     // Level index
	int                errors = 0;           // Mismatch count
	int                n_tests = 0;          // Comparison count
	int                cycles = 0;           // Timeout counter
	logic [7:0]        rst_tab [5] = '{RST_DRIVER_MODE, RST_DAC_POWER, RST_PATTERN,
		RST_SOFT_RESET, 8'h00};              // Reset values, last is unmapped
	logic [7:0]        msk_tab [5] = '{MASK_DRIVER_MODE, MASK_DAC_POWER, MASK_PATTERN,
		8'h00, 8'h00};                       // Read back after mask writes
	hv_awg_control_registers u_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.shutdown_pin_in(shutdown_pin_in), .fault_trip_in(fault_trip_in),
		.sync_pin_in(sync_pin_in), .dac_word_in(dac_word_in),
		.dac_word_valid_in(dac_word_valid_in), .driver_enable_out(driver_enable_out),
		.driver_float_out(driver_float_out), .latch_tripped_out(latch_tripped_out),
		.converter_off_out(converter_off_out), .dac_code_out(dac_code_out),
		.dac_update_out(dac_update_out), .pattern_active_out(pattern_active_out),
		.level_index_out(level_index_out), .engine_restart_out(engine_restart_out));
	// Clock, half period 50 ns
	always #50 mclk_in = ~mclk_in;
	// Cut a hang short
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			test_done();
		end
	end
	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Let n edges pass, then settle
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	// One-cycle bus write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask
	// One-cycle bus read, data taken in the answer cycle
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1;
		check(reg_rdata_out, exp);
	endtask
	// One converter word strobe
	task automatic word(input logic [WORD_W-1:0] w);
		@(posedge mclk_in);
		dac_word_in <= w;
		dac_word_valid_in <= 1'b1;
		@(posedge mclk_in);
		dac_word_valid_in <= 1'b0;
		#1;
	endtask
	// One sync pulse, index checked after each half
	task automatic sync(input logic [3:0] mid, input logic [3:0] fin);
		@(posedge mclk_in);
		sync_pin_in <= 1'b1;
		tick(5);
		check(level_index_out, mid);
		@(posedge mclk_in);
		sync_pin_in <= 1'b0;
		tick(5);
		check(level_index_out, fin);
	endtask
	// Reset values of all registers, driver enable and converter off
	task automatic t_reset_values();
		for (int i = 0; i < 5; i++) rdchk(i[7:0], rst_tab[i]);
		check(driver_enable_out, 1'b1);
		check(converter_off_out, 1'b1);
		$display("t_reset_values done");
	endtask
	// Reserved positions and unmapped address read zero
	task automatic t_masks();
		for (int i = 2; i >= 0; i--) wr(i[7:0], msk_tab[i]);
		wr(8'h04, 8'hff);
		for (int i = 0; i < 5; i++) rdchk(i[7:0], msk_tab[i]);
		check(pattern_active_out, 1'b1);
		$display("t_masks done");
	endtask
	// Soft reset restores all four registers and clears itself
	task automatic t_soft_reset();
		wr(ADDR_SOFT_RESET, 8'h01);
		check(engine_restart_out, 1'b1);
		tick(1);
		check(engine_restart_out, 1'b0);
		for (int i = 0; i < 4; i++) rdchk(i[7:0], rst_tab[i]);
		check(pattern_active_out, 1'b0);
		$display("t_soft_reset done");
	endtask
	// Power bit, shutdown pin and suppression by the clear bit
	task automatic t_power();
		wr(ADDR_DRIVER_MODE, 8'h00);
		check({driver_enable_out, driver_float_out}, 2'b01);
		@(posedge mclk_in);
		shutdown_pin_in <= 1'b1;
		wr(ADDR_DRIVER_MODE, 8'h10);
		tick(3);
		check(driver_enable_out, 1'b0);
		wr(ADDR_DRIVER_MODE, 8'h90);
		tick(3);
		check(driver_enable_out, 1'b1);
		wr(ADDR_DRIVER_MODE, 8'h10);
		@(posedge mclk_in);
		shutdown_pin_in <= 1'b0;
		tick(3);
		check(driver_enable_out, 1'b1);
		$display("t_power done");
	endtask
	// Protection trip sets the latch, clear bit releases and holds it clear
	task automatic t_latch();
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk_in);
			fault_trip_in <= 1'b1;
			@(posedge mclk_in);
			fault_trip_in <= 1'b0;
			tick(4);
			check(latch_tripped_out, k == 0);
			check(driver_enable_out, k != 0);
			wr(ADDR_DRIVER_MODE, 8'h90);
			tick(1);
			check(latch_tripped_out, 1'b0);
		end
		wr(ADDR_DRIVER_MODE, 8'h10);
		tick(2);
		check({latch_tripped_out, driver_enable_out}, 2'b01);
		$display("t_latch done");
	endtask
	// Converter sleep and shutdown coupling
	task automatic t_converter();
		wr(ADDR_DAC_POWER, 8'h00);
		check(converter_off_out, 1'b0);
		wr(ADDR_DRIVER_MODE, 8'h00);
		check(converter_off_out, 1'b1);
		wr(ADDR_DAC_POWER, 8'h20);
		check(converter_off_out, 1'b0);
		wr(ADDR_DAC_POWER, 8'h28);
		check(converter_off_out, 1'b1);
		wr(ADDR_DRIVER_MODE, 8'h10);
		wr(ADDR_DAC_POWER, 8'h00);
		$display("t_converter done");
	endtask
	// Arbitrary words in both formats, no load in pattern source without enable
	task automatic t_arbitrary();
		for (int f = 0; f < 2; f++) begin
			wr(ADDR_DAC_POWER, (f == 1) ? 8'h02 : 8'h00);
			word(14'h2abc);
			check(dac_code_out, (f == 1) ? 14'h0abc : 14'h2abc);
			check(dac_update_out, 1'b1);
		end
		wr(ADDR_DAC_POWER, 8'h00);
		wr(ADDR_DRIVER_MODE, 8'h11);
		word(14'h1234);
		check(dac_update_out, 1'b0);
		check(dac_code_out, 14'h0abc);
		$display("t_arbitrary done");
	endtask
	// Pattern stepping on both edges, wrap at depth one and fifteen
	task automatic t_pattern();
		@(posedge mclk_in);
		dac_word_in <= 14'h0155;
		sync(4'h0, 4'h0);
		wr(ADDR_PATTERN, 8'h21);
		check(pattern_active_out, 1'b1);
		sync(4'h1, 4'h1);
		check(dac_code_out, 14'h0155);
		sync(4'h0, 4'h0);
		sync(4'h1, 4'h1);
		wr(ADDR_PATTERN, 8'h31);
		sync(4'h1, 4'h0);
		sync(4'h0, 4'h1);
		wr(ADDR_PATTERN, 8'h2f);
		for (int k = 2; k <= 16; k++) sync(k[3:0], k[3:0]);
		wr(ADDR_DRIVER_MODE, 8'h10);
		tick(2);
		check({pattern_active_out, level_index_out}, 5'h00);
		$display("t_pattern done");
	endtask
	// Print counts and verdict, then stop
	task automatic test_done();
		$display("Counts: %0d compares, %0d mismatches", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		t_reset_values();
		t_masks();
		t_soft_reset();
		t_power();
		t_latch();
		t_converter();
		t_arbitrary();
		t_pattern();
		test_done();
	end
endmodule
bind hv_awg_control_registers hv_awg_ctrl_props u_props (.*);
